// ---- design/lfd_spi_cmd_port.sv ----
// Serial command port of the LF antenna driver: SPI slave and decoder
//
// Summary of operation
// - Eight-bit serial slave, clock up to 1 MHz.
// - Data output driven only while selected.
// - Never starts transfers nor makes clock.
// - Sample input on rising serial clock edge.
// - Present output LSB, shift on falling edge.
// - Both polarity/phase 0 and 1/1 supported.
// - Power-down: inverters off, pull-down on.
// - Qualified oscillator switches one inverter off.
// - First reply: system and modulator ready bits.
// - 0x11 clear faults, 0x21 stop, 0x41 sleep.
// - 0x04 writes current and modulation select.
// - 0x06 reads current and modulation select.
// - Modulation select: zero ASK, one PSK.
// - 0x08 writes baud rate and prescaler enable.
// - 0x0A reads baud rate and prescaler enable.
// - 0x0E returns fault byte second word.
// - Fault byte layout, top two bits zero.
// - 0x02 returns free buffer bit slots.
// - Bit seven set starts LF data load.
// - LF data words echo previous master word.
// - Words are eight bits, LSB first.
// - Unknown command sets illegal-command fault bit.
// - Stop discards buffer, idles driver.
// - Sleep after 2048 oscillator cycles unless reselected.
`default_nettype none
module lfd_spi_cmd_port
  import lfd_pkg::*;
(
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  nrst,
  // Serial port pins
  input  wire logic                  port_select,
  input  wire logic                  port_sclk,
  input  wire logic                  port_serial_in,
  output logic                       port_serial_out,
  output logic                       port_serial_out_en,
  // Oscillator
  input  wire logic                  resonator_input,
  input  wire logic                  osc_qualified,
  output logic                       osc_pulldown_en,
  output logic                       osc_inv_a_en,
  output logic                       osc_inv_b_en,
  output logic                       system_ready_flag,
  // Modulator and buffer side
  input  wire logic                  modulator_ready,
  input  wire logic [6:0]            free_bit_slots,
  input  wire lfd_pkg::lfd_diag_t    diag_faults,
  output lfd_pkg::lfd_lf_word_t      lf_word,
  output logic                       modulator_start,
  output logic                       modulator_stop,
  output logic                       driver_halt,
  output logic                       power_stage_fault,
  // Configuration
  output lfd_pkg::lfd_mod_cfg_t      mod_cfg,
  output lfd_pkg::lfd_tim_cfg_t      tim_cfg
);
  import lfd_pkg::*;

  typedef enum logic [1:0] {
    LFD_PH_CMD,
    LFD_PH_ARG,
    LFD_PH_LF
  } lfd_phase_t;

  typedef enum logic [1:0] {
    LFD_OSC_OFF,
    LFD_OSC_QUAL,
    LFD_OSC_RUN,
    LFD_OSC_PD_WAIT
  } lfd_osc_t;

  // ---------------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n;

  // Asynchronous assert, release through two flops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [4:0] pin_s3_q;
  logic       sel_s;
  logic       sclk_s;
  logic       sdi_s;
  logic       osc_ok_s;
  logic       res_s;
  logic       sel_rise;
  logic       sel_fall;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       res_rise;

  // Two flops per pin; the third stage only feeds edge detection
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
      pin_s3_q <= 5'h00;
    end else begin
      pin_s1_q <= {resonator_input, osc_qualified, port_serial_in,
                   port_sclk, port_select};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign sel_s     = pin_s2_q[0];
  assign sclk_s    = pin_s2_q[1];
  assign sdi_s     = pin_s2_q[2];
  assign osc_ok_s  = pin_s2_q[3];
  assign res_s     = pin_s2_q[4];
  assign sel_rise  = sel_s & ~pin_s3_q[0];
  assign sel_fall  = ~sel_s & pin_s3_q[0];
  // Oversampling the serial clock fifty times keeps 1 MHz safe
  assign sclk_rise = sel_s & sclk_s & ~pin_s3_q[1];
  assign sclk_fall = sel_s & ~sclk_s & pin_s3_q[1];
  assign res_rise  = res_s & ~pin_s3_q[4];

  // ---------------------------------------------------------------------
  // Shift registers
  // ---------------------------------------------------------------------
  logic [2:0] bit_cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  logic       shift_pend_q;
  logic       word_done;
  logic [7:0] rx_word;
  logic [7:0] reply_d;
  logic [7:0] status_byte;

  assign word_done = sclk_rise && (bit_cnt_q == BIT_CNT_LAST);
  // LSB arrives first, so new bits enter at the top
  assign rx_word   = {sdi_s, rx_q[7:1]};

  // First reply word layout, shared by every command
  assign status_byte = 8'({system_ready_flag, 5'h00, modulator_ready,
                           1'b0});

  // Bit counter cleared on deselect; input register keeps its value
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= BIT_CNT_RESET;
      rx_q      <= 8'h00;
    end else if (!sel_s) begin
      bit_cnt_q <= BIT_CNT_RESET;
    end else if (sclk_rise) begin
      rx_q      <= rx_word;
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // Output register: a falling edge shifts only after a rising edge of
  // the same word, so the leading falling edge of scheme 1/1 keeps bit 0
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_q         <= 8'h00;
      shift_pend_q <= 1'b0;
    end else if (sel_rise) begin
      tx_q         <= status_byte;
      shift_pend_q <= 1'b0;
    end else if (word_done) begin
      tx_q         <= reply_d;
      shift_pend_q <= 1'b0;
    end else if (sclk_rise) begin
      shift_pend_q <= 1'b1;
    end else if (sclk_fall && shift_pend_q) begin
      tx_q         <= {1'b0, tx_q[7:1]};
      shift_pend_q <= 1'b0;
    end
  end

  // Output pin and enable; drive only while selected, never any clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_serial_out    <= 1'b0;
      port_serial_out_en <= 1'b0;
    end else begin
      port_serial_out    <= tx_q[0];
      port_serial_out_en <= sel_s;
    end
  end

  // ---------------------------------------------------------------------
  // Command decoder
  // ---------------------------------------------------------------------
  lfd_phase_t phase_q;
  logic [7:0] cmd_q;
  logic [6:0] lf_left_q;
  logic       cmd_word;
  logic       arg_word;
  logic       lf_word_in;
  logic       cmd_illegal;
  logic [6:0] lf_take;
  logic [5:0] fault_q;

  // Recognised single and two-word command codes
  function automatic logic cmd_known(input logic [7:0] w);
    unique case (w)
      CMD_STATUS, CMD_FAULT_CLEAR, CMD_MOD_STOP, CMD_POWER_DOWN,
      CMD_WR_MOD_CFG, CMD_RD_MOD_CFG, CMD_WR_TIM_CFG, CMD_RD_TIM_CFG,
      CMD_RD_FAULT, CMD_RD_FREE_SPACE: cmd_known = 1'b1;
      default:                         cmd_known = w[CMD_LF_LOAD_BIT];
    endcase
  endfunction

  assign cmd_word    = word_done && (phase_q == LFD_PH_CMD);
  assign arg_word    = word_done && (phase_q == LFD_PH_ARG);
  assign lf_word_in  = word_done && (phase_q == LFD_PH_LF);
  assign cmd_illegal = cmd_word && !cmd_known(rx_word);
  assign lf_take     = (lf_left_q > LF_BITS_PER_WORD) ?
                       LF_BITS_PER_WORD : lf_left_q;

  // Reply for the word that follows the one just completed
  always_comb begin
    reply_d = status_byte;
    if (cmd_word) begin
      unique case (rx_word)
        CMD_WR_MOD_CFG:    reply_d = CMD_WR_MOD_CFG;
        CMD_WR_TIM_CFG:    reply_d = CMD_WR_TIM_CFG;
        CMD_RD_MOD_CFG:    reply_d = 8'({mod_cfg.drive_current_select,
                                         1'b0,
                                         mod_cfg.modulation_select});
        CMD_RD_TIM_CFG:    reply_d = 8'({tim_cfg.baud_rate_select,
                                         tim_cfg.clock_out_prescale_en});
        CMD_RD_FAULT:      reply_d = {2'h0, fault_q};
        CMD_RD_FREE_SPACE: reply_d = {1'b0, free_bit_slots};
        default: begin
          if (rx_word[CMD_LF_LOAD_BIT] && rx_word[6:0] != 7'h00) begin
            reply_d = rx_word;
          end
        end
      endcase
    end else if (lf_word_in && lf_left_q > LF_BITS_PER_WORD) begin
      reply_d = rx_word;
    end
  end

  // Word position; a deselect always returns to a command word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_q   <= LFD_PH_CMD;
      cmd_q     <= 8'h00;
      lf_left_q <= 7'h00;
    end else if (!sel_s) begin
      phase_q   <= LFD_PH_CMD;
    end else if (cmd_word) begin
      cmd_q <= rx_word;
      if (rx_word[CMD_LF_LOAD_BIT]) begin
        lf_left_q <= rx_word[6:0];
        phase_q   <= (rx_word[6:0] == 7'h00) ? LFD_PH_CMD : LFD_PH_LF;
      // Every two-word code has a bit set in 3..1, no single-word one does
      end else if (cmd_known(rx_word) && rx_word[3:1] != 3'h0) begin
        phase_q <= LFD_PH_ARG;
      end else begin
        phase_q <= LFD_PH_CMD;
      end
    end else if (arg_word) begin
      phase_q <= LFD_PH_CMD;
    end else if (lf_word_in) begin
      lf_left_q <= lf_left_q - lf_take;
      if (lf_left_q <= LF_BITS_PER_WORD) begin
        phase_q <= LFD_PH_CMD;
      end
    end
  end

  // LF half-bit words to the buffer; each word also starts the modulator
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lf_word         <= '0;
      modulator_start <= 1'b0;
    end else begin
      lf_word.valid   <= lf_word_in;
      modulator_start <= lf_word_in;
      if (lf_word_in) begin
        lf_word.lf_half_bits <= rx_word;
        lf_word.bit_count    <= lf_take[2:0];
      end
    end
  end

  // ---------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------
  // Kept through power-down so they can be read back afterwards
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mod_cfg.drive_current_select <= MODCFG_CUR_RESET;
      mod_cfg.modulation_select    <= lfd_mod_scheme_t'(MODCFG_SEL_RESET);
      tim_cfg.baud_rate_select      <= TIMCFG_BAUD_RESET;
      tim_cfg.clock_out_prescale_en <= TIMCFG_PRESC_RESET;
    end else if (arg_word && cmd_q == CMD_WR_MOD_CFG) begin
      mod_cfg.drive_current_select <= rx_word[MODCFG_CUR_LSB +: 4];
      mod_cfg.modulation_select    <=
        lfd_mod_scheme_t'(rx_word[MODCFG_SEL_BIT]);
    end else if (arg_word && cmd_q == CMD_WR_TIM_CFG) begin
      tim_cfg.baud_rate_select      <= rx_word[TIMCFG_BAUD_LSB +: 2];
      tim_cfg.clock_out_prescale_en <= rx_word[TIMCFG_PRESC_BIT];
    end
  end

  // ---------------------------------------------------------------------
  // Fault memory
  // ---------------------------------------------------------------------
  logic fault_clear;
  logic pd_cmd;
  assign fault_clear = cmd_word && (rx_word == CMD_FAULT_CLEAR);
  assign pd_cmd      = cmd_word && (rx_word == CMD_POWER_DOWN);

  // Sticky bits; a detection in the clearing cycle survives the clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fault_q <= FAULT_RESET;
    end else begin
      fault_q <= (fault_q & ~{6{fault_clear}}) |
                 {cmd_illegal, diag_faults};
    end
  end

  // Only driver faults stop the power stages, not a bad command
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_stage_fault <= 1'b0;
    end else begin
      power_stage_fault <= |fault_q[FAULT_ILLEGAL_BIT-1:0];
    end
  end

  // ---------------------------------------------------------------------
  // Oscillator control and power-down
  // ---------------------------------------------------------------------
  lfd_osc_t   osc_q;
  logic       pd_req_q;
  logic [11:0] pd_timer_q;
  logic       pd_expire;

  assign pd_expire = (osc_q == LFD_OSC_PD_WAIT) && !sel_s && res_rise &&
                     (pd_timer_q == PD_TIMER_LAST);

  // A sleep request lives until the next command word or a deselect
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pd_req_q <= 1'b0;
    end else if (cmd_word) begin
      pd_req_q <= pd_cmd;
    end else if (sel_fall) begin
      pd_req_q <= 1'b0;
    end
  end

  // Oscillator states: off, qualifying, running, waiting to sleep
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_q <= LFD_OSC_OFF;
    end else begin
      unique case (osc_q)
        LFD_OSC_OFF:     if (sel_s) begin
          osc_q <= LFD_OSC_QUAL;
        end
        LFD_OSC_QUAL:    if (osc_ok_s) begin
          osc_q <= LFD_OSC_RUN;
        end
        LFD_OSC_RUN:     if (sel_fall && pd_req_q) begin
          osc_q <= LFD_OSC_PD_WAIT;
        end
        LFD_OSC_PD_WAIT: begin
          if (sel_s) begin
            osc_q <= LFD_OSC_RUN;
          end else if (pd_expire) begin
            osc_q <= LFD_OSC_OFF;
          end
        end
      endcase
    end
  end

  // Timeout counted on resonator edges, not on the system clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pd_timer_q <= 12'h000;
    end else if (osc_q != LFD_OSC_PD_WAIT) begin
      pd_timer_q <= 12'h000;
    end else if (res_rise) begin
      pd_timer_q <= pd_timer_q + 12'h001;
    end
  end

  // Oscillator drive: none while off, both inverters until qualified, then one only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_pulldown_en   <= 1'b1;
      osc_inv_a_en      <= 1'b0;
      osc_inv_b_en      <= 1'b0;
      system_ready_flag <= 1'b0;
    end else begin
      osc_pulldown_en   <= (osc_q == LFD_OSC_OFF);
      osc_inv_a_en      <= (osc_q != LFD_OSC_OFF);
      osc_inv_b_en      <= (osc_q == LFD_OSC_QUAL);
      system_ready_flag <= (osc_q == LFD_OSC_RUN) ||
                           (osc_q == LFD_OSC_PD_WAIT);
    end
  end

  // Stop flushes the buffer; the sleep wait also halts the driver
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      modulator_stop <= 1'b0;
      driver_halt    <= 1'b0;
    end else begin
      modulator_stop <= (cmd_word && rx_word == CMD_MOD_STOP) ||
                        (osc_q == LFD_OSC_RUN && sel_fall && pd_req_q);
      driver_halt    <= (osc_q == LFD_OSC_PD_WAIT) ||
                        (osc_q == LFD_OSC_OFF);
    end
  end

endmodule
`default_nettype wire

// ---- design/lfd_pkg.sv ----
// Package with constants and types of the LF driver serial command port
`default_nettype none
package lfd_pkg;

  // ---------------------------------------------------------------------
  // Serial word framing
  // ---------------------------------------------------------------------
  localparam int unsigned SPI_WORD_BITS     = 8;
  localparam int unsigned SPI_SCLK_MAX_KHZ  = 1000;
  localparam logic [2:0]  BIT_CNT_LAST      = 3'h7;
  localparam logic [2:0]  BIT_CNT_RESET     = 3'h0;

  // ---------------------------------------------------------------------
  // Command codes of the first word
  // ---------------------------------------------------------------------
  localparam logic [7:0] CMD_STATUS        = 8'h00;
  localparam logic [7:0] CMD_FAULT_CLEAR   = 8'h11;
  localparam logic [7:0] CMD_MOD_STOP      = 8'h21;
  localparam logic [7:0] CMD_POWER_DOWN    = 8'h41;
  localparam logic [7:0] CMD_WR_MOD_CFG    = 8'h04;
  localparam logic [7:0] CMD_RD_MOD_CFG    = 8'h06;
  localparam logic [7:0] CMD_WR_TIM_CFG    = 8'h08;
  localparam logic [7:0] CMD_RD_TIM_CFG    = 8'h0a;
  localparam logic [7:0] CMD_RD_FAULT      = 8'h0e;
  localparam logic [7:0] CMD_RD_FREE_SPACE = 8'h02;
  localparam int unsigned CMD_LF_LOAD_BIT  = 7;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int unsigned STAT_SYS_READY_BIT = 7;
  localparam int unsigned STAT_MOD_READY_BIT = 1;
  localparam int unsigned MODCFG_CUR_LSB     = 2;
  localparam int unsigned MODCFG_SEL_BIT     = 0;
  localparam int unsigned TIMCFG_BAUD_LSB    = 1;
  localparam int unsigned TIMCFG_PRESC_BIT   = 0;
  localparam int unsigned FAULT_ILLEGAL_BIT  = 5;
  localparam logic [6:0]  LF_BITS_PER_WORD   = 7'h04;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [3:0] MODCFG_CUR_RESET   = 4'h0;
  localparam logic       MODCFG_SEL_RESET   = 1'b0;
  localparam logic [1:0] TIMCFG_BAUD_RESET  = 2'h0;
  localparam logic       TIMCFG_PRESC_RESET = 1'b0;
  localparam logic [5:0] FAULT_RESET        = 6'h00;

  // ---------------------------------------------------------------------
  // Power-down timer, counted in resonator cycles
  // ---------------------------------------------------------------------
  localparam int unsigned PD_TIMEOUT_OSC_CYCLES = 2048;
  localparam logic [11:0] PD_TIMER_LAST =
    12'(PD_TIMEOUT_OSC_CYCLES - 1);

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic {
    LFD_SCHEME_ASK,
    LFD_SCHEME_PSK
  } lfd_mod_scheme_t;

  typedef struct packed {
    logic [3:0]      drive_current_select;
    lfd_mod_scheme_t modulation_select;
  } lfd_mod_cfg_t;

  typedef struct packed {
    logic [1:0] baud_rate_select;
    logic       clock_out_prescale_en;
  } lfd_tim_cfg_t;

  typedef struct packed {
    logic footpoint_overcurrent_fault;
    logic open_load_fault;
    logic short_to_battery_fault;
    logic short_to_ground_fault;
    logic overtemperature_fault;
  } lfd_diag_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] bit_count;
    logic [7:0] lf_half_bits;
  } lfd_lf_word_t;

endpackage
`default_nettype wire

// ---- tb/lfd_checker.sv ----
// Concurrent checks on the ports of the serial command port
`default_nettype none
module lfd_checker
  import lfd_pkg::*;
(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   nrst,
  // Observed ports
  input  wire logic                   port_select,
  input  wire logic                   port_serial_out_en,
  input  wire logic                   resonator_input,
  input  wire logic                   osc_pulldown_en,
  input  wire logic                   osc_inv_a_en,
  input  wire logic                   osc_inv_b_en,
  input  wire logic                   system_ready_flag,
  input  wire lfd_pkg::lfd_diag_t     diag_faults,
  input  wire lfd_pkg::lfd_lf_word_t  lf_word,
  input  wire logic                   modulator_start,
  input  wire logic                   modulator_stop,
  input  wire logic                   power_stage_fault
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PD_EDGES = 2048;
  logic [12:0] res_cnt_q;
  // Resonator edges seen while deselected; saturates so it cannot wrap
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) res_cnt_q <= '0;
    else if (port_select) res_cnt_q <= '0;
    else if ($rose(resonator_input) && !res_cnt_q[12])
      res_cnt_q <= res_cnt_q + 13'h1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // Wake-up: pull-down released and both inverters powered
  sequence wake_s;
    ##[1:8] (!osc_pulldown_en && osc_inv_a_en && osc_inv_b_en);
  endsequence
  AST_OUT_RELEASED: assert property (
    !port_select [*6] |-> !port_serial_out_en)
    else $error("serial output enabled while deselected");
  AST_START_WITH_WORD: assert property (
    lf_word.valid == modulator_start)
    else $error("modulator start not paired with LF word");
  AST_WORD_PULSE: assert property (
    lf_word.valid |=> !lf_word.valid)
    else $error("LF word valid held over one cycle");
  AST_BIT_COUNT: assert property (
    lf_word.valid |-> lf_word.bit_count inside {[3'h1:3'h4]})
    else $error("LF word bit count out of range");
  AST_SLEEP_STATE: assert property (
    osc_pulldown_en |-> !osc_inv_a_en && !osc_inv_b_en
                        && !system_ready_flag)
    else $error("oscillator powered during power-down");
  AST_WAKE: assert property (
    $rose(port_select) && osc_pulldown_en |-> wake_s)
    else $error("select did not start the oscillator");
  AST_ONE_INVERTER: assert property (
    system_ready_flag |-> osc_inv_a_en && !osc_inv_b_en)
    else $error("second inverter on after qualification");
  AST_DIAG_FAULT: assert property (
    (|diag_faults) |-> ##[1:4] power_stage_fault)
    else $error("diagnosis fault not flagged");
  AST_STOP_PULSE: assert property (
    modulator_stop |=> !modulator_stop)
    else $error("modulator stop longer than one cycle");
  AST_SLEEP_TIMER: assert property (
    $rose(osc_pulldown_en) |-> res_cnt_q >= PD_EDGES
                               && res_cnt_q <= PD_EDGES + 8)
    else $error("power-down timer length wrong");
endmodule
bind lfd_spi_cmd_port lfd_checker u_chk (
  .clock, .nrst, .port_select, .port_serial_out_en, .resonator_input,
  .osc_pulldown_en, .osc_inv_a_en, .osc_inv_b_en, .system_ready_flag,
  .diag_faults, .lf_word, .modulator_start, .modulator_stop,
  .power_stage_fault);
`default_nettype wire

// ---- tb/lfd_spi_master.sv ----
// Serial master model standing on the far side of the command port
`default_nettype none
module lfd_spi_master (
  // Clock and returned data line
  input  wire logic       clock,
  input  wire logic       sdo,
  // Master pins
  output var  logic       sel,
  output var  logic       sclk,
  output var  logic       sdi,
  // Word received on the data line
  output var  logic       rx_vld,
  output var  logic [7:0] rx
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 25;  // Half period under 1 MHz
  logic cpol;
  initial begin
    {sel, sclk, sdi, rx_vld, cpol} = '0;
    rx = 8'h00;
  end
  // Data line floats between frames: keep it moving, not parked
  always @(posedge clock) begin
    if (!sel) sdi <= ~sdi;
  end
  // Select edge; serial clock parked at the scheme's idle level
  // Clock settles first so no edge coincides with the select edge
  task automatic frame(input logic on, input logic pol);
    @(posedge clock);
    cpol <= pol;
    sclk <= pol;
    repeat (4) @(posedge clock);
    sel  <= on;
    repeat (12) @(posedge clock);
  endtask
  // One word LSB first; reply bit taken at each rising edge
  task automatic xfer(input logic [7:0] tx);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      sclk <= 1'b0;
      sdi  <= tx[i];
      repeat (HALF) @(posedge clock);
      sclk <= 1'b1;
      r[i] = sdo;
      repeat (HALF) @(posedge clock);
    end
    sclk   <= cpol;
    rx     <= r;
    rx_vld <= 1'b1;
    @(posedge clock);
    rx_vld <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/lfd_spi_cmd_port_test.sv ----
// Self-checking bench for the LF driver serial command port
`default_nettype none
module lfd_spi_cmd_port_test;
  import lfd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic         clock, nrst, res_in, osc_q, mod_rdy, so, so_en, sel;
  logic         sclk, sdi, rx_vld, pd, inv_a, inv_b, ready, mstart;
  logic         mstop, halt, psf, rdy_exp;
  logic [7:0]   rx, w, d1, d2;
  logic [6:0]   free;
  logic [4:0]   d;
  lfd_diag_t    diag;
  lfd_lf_word_t lfw;
  lfd_mod_cfg_t mcfg;
  lfd_tim_cfg_t tcfg;
  logic [7:0]   rq[$];
  logic [11:0]  lq[$];
  int           fails, tests_run, seed, stops;
  wire          sdo_w = so_en ? so : 1'bz;  // Tri-state pin
  lfd_spi_cmd_port dut (
    .clock, .nrst, .port_select(sel), .port_sclk(sclk),
    .port_serial_in(sdi), .port_serial_out(so),
    .port_serial_out_en(so_en), .resonator_input(res_in),
    .osc_qualified(osc_q), .osc_pulldown_en(pd), .osc_inv_a_en(inv_a),
    .osc_inv_b_en(inv_b), .system_ready_flag(ready),
    .modulator_ready(mod_rdy), .free_bit_slots(free),
    .diag_faults(diag), .lf_word(lfw), .modulator_start(mstart),
    .modulator_stop(mstop), .driver_halt(halt),
    .power_stage_fault(psf), .mod_cfg(mcfg), .tim_cfg(tcfg));
  lfd_spi_master m (
    .clock, .sdo(sdo_w), .sel, .sclk, .sdi, .rx_vld, .rx);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Resonator runs at half the system clock
  always @(posedge clock) res_in <= ~res_in;
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] st();
    return {rdy_exp, 5'h0, mod_rdy, 1'b0};
  endfunction
  task automatic wd(input logic [7:0] tx, input logic [7:0] exp);
    rq.push_back(exp);
    m.xfer(tx);
  endtask
  // Side inputs are re-rolled per frame and held while it lasts
  task automatic open_f(input logic pol);
    @(posedge clock);
    mod_rdy <= 1'($random(seed));
    free    <= 7'($random(seed));
    m.frame(1'b1, pol);
  endtask
  // Each reply or buffer word is matched against the oldest note
  always @(posedge clock) begin
    if (rx_vld) check({4'h0, rx}, {4'h0, rq.pop_front()});
    if (lfw.valid) check(lfw, lq.pop_front());
    if (mstop) stops++;
  end
  // Hang guard: the sequence needs well under a millisecond
  initial begin
    #1500us;
    fails++;
    conclude();
  end
  initial begin
    {nrst, res_in, osc_q, mod_rdy, rdy_exp} = '0;
    fails = 0;
    stops = 0;
    tests_run = 0;
    seed = 32'h9e4d;
    free = 7'h00;
    diag = '0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    repeat (8) @(posedge clock);
    check({8'h0, pd, inv_a, inv_b, ready}, 12'h008);
    m.frame(1'b1, 1'b0);
    check({8'h0, pd, inv_a, inv_b, ready}, 12'h006);
    osc_q <= 1'b1;
    repeat (8) @(posedge clock);
    check({8'h0, pd, inv_a, inv_b, ready}, 12'h005);
    rdy_exp = 1'b1;
    m.frame(1'b0, 1'b0);
    for (int p = 0; p < 2; p++) begin
      w = 8'($random(seed));
      open_f(p[0]);
      wd(8'h00, st());
      wd(8'h11, st());
      wd(8'h21, st());
      wd(8'h04, st());
      wd(w, 8'h04);
      wd(8'h06, st());
      wd(~w, {2'h0, w[5:2], 1'b0, w[0]});
      wd(8'h08, st());
      wd(w, 8'h08);
      wd(8'h0a, st());
      wd(~w, {5'h0, w[2:0]});
      wd(8'h02, st());
      wd(w, {1'b0, free});
      m.frame(1'b0, p[0]);
      check({4'h0, mcfg, tcfg}, {4'h0, w[5:2], w[0], w[2:0]});
    end
    // Unknown code and diagnosis faults, then clearing
    open_f(1'b0);
    d = 5'($random(seed)) | 5'h01;
    wd(8'h03, st());
    check({11'h0, psf}, 12'h000);
    @(posedge clock);
    diag <= d;
    repeat (4) @(posedge clock);
    diag <= '0;
    wd(8'h0e, st());
    wd(w, {3'h1, d});
    wd(8'h11, st());
    wd(8'h0e, st());
    wd(w, 8'h00);
    // LF load of six bits, an empty load, then an aborted write
    d1 = 8'($random(seed));
    d2 = 8'($random(seed));
    lq.push_back({1'b1, 3'h4, d1});
    lq.push_back({1'b1, 3'h2, d2});
    wd(8'h86, st());
    wd(d1, 8'h86);
    wd(d2, d1);
    wd(8'h80, st());
    wd(8'h04, st());
    m.frame(1'b0, 1'b0);
    open_f(1'b0);
    wd(8'h00, st());
    wd(8'h06, st());
    wd(w, {2'h0, w[5:2], 1'b0, w[0]});
    // Power-down cancelled by reselect, then carried through
    wd(8'h41, st());
    m.frame(1'b0, 1'b0);
    repeat (100) @(posedge clock);
    check({10'h0, halt, ready}, 12'h003);
    open_f(1'b0);
    wd(8'h00, st());
    check({10'h0, halt, ready}, 12'h001);
    wd(8'h41, st());
    m.frame(1'b0, 1'b0);
    repeat (4400) @(posedge clock);
    check({8'h0, pd, inv_a, inv_b, ready}, 12'h008);
    check(12'(stops), 12'h004);
    conclude();
  end
endmodule
`default_nettype wire
